// *** spi_serial_port.sv ***
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - data shifts through a 16-bit shift register beside a software buffer.
// - master drives serial clock pin; slave takes it as input.
// - master clock-disable bit stops the clock and releases its pin.
// - data-output-disable bit releases the data output pin.
// - master sample phase: end of data time if set, middle if clear.
// - clock-edge clear changes data idle-to-active, set active-to-idle.
// - slave select-pin-enable decides whether select pin is used.
// - clock polarity set idles high, clear idles low.
// - primary prescale 00 divides by 64; secondary divides further.
// - frame sync polarity set is active-high, clear active-low.
module spi_serial_port (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [15:0] reg_rdata,
   // serial clock pin
   input  wire logic        serial_clock_pin_in,
   output logic             serial_clock_pin_out,
   output logic             serial_clock_pin_oe,
   // data pins
   input  wire logic        serial_data_in_pin,
   output logic             serial_data_out_pin,
   output logic             serial_data_out_oe,
   // slave select / frame sync pin
   input  wire logic        slave_select_pin_in,
   output logic             slave_select_pin_out,
   output logic             slave_select_pin_oe,
   // interrupt
   output logic             irq
);
   import serial_port_pkg::*;

   logic [15:0] status_control;
   logic [15:0] serial_control_one;
   logic [15:0] serial_control_two;
   logic [15:0] tx_buffer;
   logic [15:0] data_buffer;
   logic [15:0] shift_register;
   logic [15:0] tx_shift;
   logic        transmit_full_flag;
   logic        receive_full_flag;
   logic        receive_overflow_flag;
   logic [IRQ_WIDTH-1:0] irq_status;
   logic [IRQ_WIDTH-1:0] irq_mask;
   xfer_state_t state;
   logic [4:0]  bit_count;
   logic [8:0]  div_count;
   logic        sck_int;
   logic        half_tick;
   logic        frame_active;
   logic        fsync_hold;
   logic [2:0]  sck_sync;
   logic [1:0]  ss_sync;
   logic [1:0]  sdi_sync;

   // control field views
   logic       port_enable;
   logic       clock_pin_disable;
   logic       data_out_disable;
   logic       word_size_select;
   logic       sample_phase;
   logic       clock_edge;
   logic       select_pin_enable;
   logic       clock_polarity;
   logic       master_enable;
   logic [2:0] secondary_prescale;
   logic [1:0] primary_prescale;
   logic       framed_enable;
   logic       frame_sync_direction;
   logic       frame_sync_polarity;
   logic       frame_sync_edge;
   assign port_enable          = status_control[STAT_PORT_ENABLE];
   assign clock_pin_disable    = serial_control_one[C1_CLOCK_PIN_DIS];
   assign data_out_disable     = serial_control_one[C1_DATA_OUT_DIS];
   assign word_size_select     = serial_control_one[C1_WORD_SIZE];
   assign sample_phase         = serial_control_one[C1_SAMPLE_PHASE];
   assign clock_edge           = serial_control_one[C1_CLOCK_EDGE];
   assign select_pin_enable    = serial_control_one[C1_SELECT_PIN_EN];
   assign clock_polarity       = serial_control_one[C1_CLOCK_POLARITY];
   assign master_enable        = serial_control_one[C1_MASTER_ENABLE];
   assign secondary_prescale   = serial_control_one[C1_SEC_PRESCALE_LO +: 3];
   assign primary_prescale     = serial_control_one[C1_PRI_PRESCALE_LO +: 2];
   assign framed_enable        = serial_control_two[C2_FRAMED_ENABLE];
   assign frame_sync_direction = serial_control_two[C2_FSYNC_DIRECTION];
   assign frame_sync_polarity  = serial_control_two[C2_FSYNC_POLARITY];
   assign frame_sync_edge      = serial_control_two[C2_FSYNC_EDGE];

   // divider reload: half-period of the master clock in system cycles, minus one
   function automatic logic [8:0] half_period(input logic [1:0] pri, input logic [2:0] sec);
      logic [8:0] p;
      logic [8:0] s;
      p = 9'h000;
      s = {6'h00, 3'h7 - sec} + 9'h001;
      case (pri)
         2'b00:   p = 9'h020;
         2'b01:   p = 9'h008;
         2'b10:   p = 9'h002;
         default: p = 9'h001;
      endcase
      half_period = 9'((p * s) - 9'h001);
   endfunction : half_period

   logic       wr_data;
   logic       rd_data;
   logic       load_word;
   logic       word_done;
   logic [4:0] word_len;
   logic       edge_active;
   logic       edge_idle;
   logic       sample_now;
   logic       change_now;
   logic       slave_selected;
   logic       slave_sck;
   logic       slave_sck_prev;
   logic       sdi;
   assign wr_data   = reg_write && reg_addr == ADDR_DATA_BUFFER;
   assign rd_data   = reg_read && reg_addr == ADDR_DATA_BUFFER;
   assign word_len  = word_size_select ? 5'(WORD_BITS) : 5'(BYTE_BITS);
   assign sdi       = sdi_sync[1];
   assign slave_sck      = sck_sync[1] ^ clock_polarity;
   assign slave_sck_prev = sck_sync[2] ^ clock_polarity;
   assign slave_selected = !select_pin_enable || framed_enable || !ss_sync[1];

   // clock edges in active sense: rising is idle-to-active
   always_comb begin
      if (master_enable) begin
         edge_active = half_tick && !sck_int;
         edge_idle   = half_tick && sck_int;
      end else begin
         edge_active = slave_sck && !slave_sck_prev && slave_selected;
         edge_idle   = !slave_sck && slave_sck_prev && slave_selected;
      end
   end
   // framed modes ignore the edge bit
   assign change_now = (clock_edge && !framed_enable) ? edge_idle : edge_active;
   // end-of-time sampling uses the next change edge
   assign sample_now = (master_enable && sample_phase) ? change_now
                     : ((clock_edge && !framed_enable) ? edge_active : edge_idle);
   assign load_word  = state == ST_IDLE && transmit_full_flag && port_enable;
   assign word_done  = state == ST_DONE;

   // input synchronisers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sck_sync <= 3'h0;
         ss_sync  <= 2'h3;
         sdi_sync <= 2'h0;
      end else if (clk_en) begin
         sck_sync <= {sck_sync[1:0], serial_clock_pin_in};
         ss_sync  <= {ss_sync[0], slave_select_pin_in};
         sdi_sync <= {sdi_sync[0], serial_data_in_pin};
      end
   end

   // registers written by software
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_control     <= REG_RESET;
         serial_control_one <= REG_RESET;
         serial_control_two <= REG_RESET;
         irq_mask           <= '0;
      end else if (clk_en && reg_write) begin
         case (reg_addr)
            ADDR_STATUS_CONTROL: status_control <= reg_wdata & STAT_WR_MASK;
            ADDR_CONTROL_ONE:    serial_control_one <= reg_wdata & C1_WR_MASK;
            ADDR_CONTROL_TWO:    serial_control_two <= reg_wdata & C2_WR_MASK;
            ADDR_IRQ_MASK:       irq_mask <= reg_wdata[IRQ_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // buffer flags; hardware set wins over clear, but port disable clears both full flags over any set
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_buffer             <= 16'h0000;
         transmit_full_flag    <= 1'b0;
         receive_full_flag     <= 1'b0;
         receive_overflow_flag <= 1'b0;
         data_buffer           <= 16'h0000;
      end else if (clk_en) begin
         if (wr_data) begin
            tx_buffer          <= reg_wdata;
            transmit_full_flag <= 1'b1;
         end else if (load_word) begin
            transmit_full_flag <= 1'b0;
         end
         if (word_done && receive_full_flag && !rd_data) begin
            receive_overflow_flag <= 1'b1;
         end else if (reg_write && reg_addr == ADDR_STATUS_CONTROL
                      && !reg_wdata[STAT_RX_OVERFLOW]) begin
            receive_overflow_flag <= 1'b0;
         end
         if (word_done && !(receive_full_flag && !rd_data)) begin
            data_buffer       <= word_size_select ? shift_register : {8'h00, shift_register[7:0]};
            receive_full_flag <= 1'b1;
         end else if (rd_data) begin
            receive_full_flag <= 1'b0;
         end
         if (!port_enable) begin
            transmit_full_flag <= 1'b0;
            receive_full_flag  <= 1'b0;
         end
      end
   end

   // transfer engine and master clock generator
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state          <= ST_IDLE;
         shift_register <= 16'h0000;
         tx_shift       <= 16'h0000;
         bit_count      <= 5'h00;
         div_count      <= 9'h000;
         sck_int        <= 1'b0;
         half_tick      <= 1'b0;
         frame_active   <= 1'b0;
         fsync_hold     <= 1'b0;
      end else if (clk_en) begin
         half_tick <= 1'b0;
         case (state)
            ST_IDLE: begin
               sck_int <= 1'b0;
               if (load_word) begin
                  shift_register <= word_size_select ? tx_buffer : {tx_buffer[7:0], 8'h00};
                  tx_shift       <= word_size_select ? tx_buffer : {tx_buffer[7:0], 8'h00};
                  bit_count      <= word_len;
                  div_count      <= half_period(primary_prescale, secondary_prescale);
                  frame_active   <= framed_enable;
                  fsync_hold     <= framed_enable && !frame_sync_edge;
                  state          <= ST_LOAD;
               end
            end
            ST_LOAD: state <= ST_SHIFT;
            ST_SHIFT: begin
               // disabled clock freezes the master engine
               if (master_enable && !clock_pin_disable) begin
                  if (div_count == 9'h000) begin
                     div_count <= half_period(primary_prescale, secondary_prescale);
                     half_tick <= 1'b1;
                  end else begin
                     div_count <= div_count - 9'h001;
                  end
                  if (half_tick) begin
                     sck_int <= !sck_int;
                  end
               end
               if (sample_now) begin
                  shift_register <= {shift_register[14:0], sdi};
                  bit_count      <= bit_count - 5'h01;
                  fsync_hold     <= 1'b0;
                  frame_active   <= frame_active && frame_sync_edge && bit_count == word_len;
                  if (bit_count == 5'h01) begin
                     state <= ST_DONE;
                  end
               end
               // leading-edge change keeps the first bit that load already presents
               if (change_now && ((clock_edge && !framed_enable) || bit_count != word_len)) begin
                  tx_shift <= {tx_shift[14:0], 1'b0};
               end
               if (!port_enable) begin
                  state <= ST_IDLE;
               end
            end
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // pins and interrupt, all registered
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_clock_pin_out <= 1'b0;
         serial_clock_pin_oe  <= 1'b0;
         serial_data_out_pin  <= 1'b0;
         serial_data_out_oe   <= 1'b0;
         slave_select_pin_out <= 1'b1;
         slave_select_pin_oe  <= 1'b0;
         irq_status           <= '0;
         irq                  <= 1'b0;
      end else if (clk_en) begin
         serial_clock_pin_out <= sck_int ^ clock_polarity;
         serial_clock_pin_oe  <= port_enable && master_enable && !clock_pin_disable;
         serial_data_out_pin  <= tx_shift[15];
         serial_data_out_oe   <= port_enable && !data_out_disable;
         // frame sync pulse, master direction drives it
         slave_select_pin_out <= ((fsync_hold || (frame_active && state == ST_SHIFT
                                   && bit_count == word_len)) ? 1'b1 : 1'b0)
                                 ~^ frame_sync_polarity;
         slave_select_pin_oe  <= port_enable && framed_enable && !frame_sync_direction;
         irq_status[IRQ_TX_EMPTY] <= load_word || (irq_status[IRQ_TX_EMPTY] &&
            !(reg_write && reg_addr == ADDR_IRQ_STATUS && reg_wdata[IRQ_TX_EMPTY]));
         irq_status[IRQ_RX_FULL]  <= (word_done && !receive_full_flag) || (irq_status[IRQ_RX_FULL]
            && !(reg_write && reg_addr == ADDR_IRQ_STATUS && reg_wdata[IRQ_RX_FULL]));
         irq_status[IRQ_OVERFLOW] <= (word_done && receive_full_flag) || (irq_status[IRQ_OVERFLOW]
            && !(reg_write && reg_addr == ADDR_IRQ_STATUS && reg_wdata[IRQ_OVERFLOW]));
         irq <= |(irq_status & irq_mask);
      end
   end

   // read port: data one cycle after the strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (clk_en) begin
         reg_rdata <= 16'h0000;
         if (reg_read) begin
            case (reg_addr)
               ADDR_STATUS_CONTROL: reg_rdata <= status_control
                  | (16'(receive_overflow_flag) << STAT_RX_OVERFLOW)
                  | (16'(transmit_full_flag) << STAT_TX_FULL)
                  | (16'(receive_full_flag) << STAT_RX_FULL);
               ADDR_CONTROL_ONE: reg_rdata <= serial_control_one;
               ADDR_CONTROL_TWO: reg_rdata <= serial_control_two;
               ADDR_DATA_BUFFER: reg_rdata <= data_buffer;
               ADDR_IRQ_STATUS:  reg_rdata <= {13'h0, irq_status};
               ADDR_IRQ_MASK:    reg_rdata <= {13'h0, irq_mask};
               default:          reg_rdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule : spi_serial_port

// *** serial_port_pkg.sv ***
package serial_port_pkg;
   // register addresses on the plain register port
   localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_CONTROL_ONE    = 4'h1;
   localparam logic [3:0] ADDR_CONTROL_TWO    = 4'h2;
   localparam logic [3:0] ADDR_DATA_BUFFER    = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK       = 4'h5;
   // status/control fields
   localparam int STAT_PORT_ENABLE   = 15;
   localparam int STAT_HALT_IN_IDLE  = 13;
   localparam int STAT_RX_OVERFLOW   = 6;
   localparam int STAT_TX_FULL       = 1;
   localparam int STAT_RX_FULL       = 0;
   // control one fields
   localparam int C1_CLOCK_PIN_DIS   = 12;
   localparam int C1_DATA_OUT_DIS    = 11;
   localparam int C1_WORD_SIZE       = 10;
   localparam int C1_SAMPLE_PHASE    = 9;
   localparam int C1_CLOCK_EDGE      = 8;
   localparam int C1_SELECT_PIN_EN   = 7;
   localparam int C1_CLOCK_POLARITY  = 6;
   localparam int C1_MASTER_ENABLE   = 5;
   localparam int C1_SEC_PRESCALE_LO = 2;
   localparam int C1_PRI_PRESCALE_LO = 0;
   // control two fields
   localparam int C2_FRAMED_ENABLE   = 15;
   localparam int C2_FSYNC_DIRECTION = 14;
   localparam int C2_FSYNC_POLARITY  = 13;
   localparam int C2_FSYNC_EDGE      = 1;
   // writable masks and reset values
   localparam logic [15:0] STAT_WR_MASK = 16'hA000;
   localparam logic [15:0] C1_WR_MASK   = 16'h1FFF;
   localparam logic [15:0] C2_WR_MASK   = 16'hE002;
   localparam logic [15:0] REG_RESET    = 16'h0000;
   // interrupt event bits and word lengths
   localparam int IRQ_TX_EMPTY = 0;
   localparam int IRQ_RX_FULL  = 1;
   localparam int IRQ_OVERFLOW = 2;
   localparam int IRQ_WIDTH    = 3;
   localparam int WORD_BITS    = 16;
   localparam int BYTE_BITS    = 8;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LOAD  = 2'b01,
      ST_SHIFT = 2'b11,
      ST_DONE  = 2'b10
   } xfer_state_t;
endpackage : serial_port_pkg

// *** serial_port_checker.sv ***
`timescale 1ns/1ps
module serial_port_checker
   import serial_port_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        clk_en,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [15:0] reg_rdata,
   // pin enables and interrupt
   input wire logic        serial_clock_pin_oe,
   input wire logic        serial_data_out_oe,
   input wire logic        slave_select_pin_oe,
   input wire logic        irq
);
   logic [15:0] c1;
   logic        en;
   logic [2:0]  mask;
   // mirror of the software view of the configuration
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         c1   <= REG_RESET;
         en   <= 1'b0;
         mask <= 3'h0;
      end else if (clk_en && reg_write) begin
         if (reg_addr == ADDR_CONTROL_ONE) c1 <= reg_wdata & C1_WR_MASK;
         if (reg_addr == ADDR_STATUS_CONTROL) en <= reg_wdata[STAT_PORT_ENABLE];
         if (reg_addr == ADDR_IRQ_MASK) mask <= reg_wdata[2:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_off;
      (!en) [*2];
   endsequence
   sequence s_master;
      (en && c1[C1_MASTER_ENABLE] && !c1[C1_CLOCK_PIN_DIS]) [*3];
   endsequence
   sequence s_slave;
      (en && !c1[C1_MASTER_ENABLE]) [*2];
   endsequence
   AST_OFF_RELEASE: assert property (s_off |-> !serial_clock_pin_oe && !serial_data_out_oe
      && !slave_select_pin_oe) else $error("pins driven while port disabled");
   AST_MASTER_DRIVES: assert property (s_master |-> serial_clock_pin_oe)
      else $error("master not driving clock pin");
   AST_SLAVE_INPUT: assert property (s_slave |-> !serial_clock_pin_oe)
      else $error("slave driving clock pin");
   AST_CLOCK_DIS: assert property ((c1[C1_MASTER_ENABLE] && c1[C1_CLOCK_PIN_DIS]) [*2]
      |-> !serial_clock_pin_oe) else $error("disabled clock pin still driven");
   AST_DOUT_DIS: assert property (c1[C1_DATA_OUT_DIS] [*2] |-> !serial_data_out_oe)
      else $error("disabled data pin still driven");
   AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   AST_UNMAPPED: assert property (reg_read && clk_en && reg_addr > ADDR_IRQ_MASK
      |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   AST_C1_READBACK: assert property (reg_read && clk_en && reg_addr == ADDR_CONTROL_ONE
      |=> reg_rdata == $past(c1)) else $error("control one readback wrong");
   AST_IRQ_MASKED: assert property ((mask == 3'h0) [*2] |-> !irq)
      else $error("interrupt with all sources masked");
endmodule : serial_port_checker

bind spi_serial_port serial_port_checker chk (.clk, .rst_b, .clk_en, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .serial_clock_pin_oe, .serial_data_out_oe,
   .slave_select_pin_oe, .irq);

// *** spi_peer_model.sv ***
`timescale 1ns/1ps
module spi_peer_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // bench control
   input  wire logic        load,
   input  wire logic [15:0] tx_word,
   input  wire logic        idle_level,
   // serial pins and received word
   input  wire logic        sck,
   input  wire logic        mosi,
   output logic             miso,
   output logic      [15:0] rx_word
);
   logic        sck_d;
   logic        mosi_d;
   logic [15:0] tx_sr;
   wire logic   lead  = (sck_d == idle_level) && (sck != idle_level);
   wire logic   trail = (sck_d != idle_level) && (sck == idle_level);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sck_d   <= 1'b0;
         mosi_d  <= 1'b0;
         tx_sr   <= 16'h0000;
         miso    <= 1'b0;
         rx_word <= 16'h0000;
      end else begin
         sck_d  <= sck;
         mosi_d <= mosi;
         if (load) tx_sr <= tx_word;
         // data changes on the idle-to-active edge, msb first; fill keeps the line moving
         else if (lead) begin
            miso  <= tx_sr[15];
            tx_sr <= {tx_sr[14:0], ~tx_sr[15]};
         end
         // take the data level held just before the clock edge, as a real receiver does
         if (trail) rx_word <= {rx_word[14:0], mosi_d};
      end
   end
endmodule : spi_peer_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import serial_port_pkg::*;
   typedef struct packed { logic [15:0] exp; logic [15:0] msk; } note_t;
   logic        clk, rst_b, clk_en, reg_write, reg_read, rd_d1, pol, peer_load, ss_b;
   logic        sck_o, sck_oe, sdo, sdo_oe, miso, ss_o, ss_oe, irq, sck_w, sdo_w;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, last_rdata, peer_tx, peer_rx;
   note_t       notes[$];
   note_t       n;
   int          bad_count, checks, cycles;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // released lines show a level that changes every cycle
   assign sck_w = sck_oe ? sck_o : cycles[0];
   assign sdo_w = sdo_oe ? sdo : ~cycles[0];
   spi_serial_port uut (.clk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
      .serial_clock_pin_oe(sck_oe), .serial_data_in_pin(miso), .serial_data_out_pin(sdo),
      .serial_data_out_oe(sdo_oe), .slave_select_pin_in(ss_b), .slave_select_pin_out(ss_o),
      .slave_select_pin_oe(ss_oe), .irq);
   spi_peer_model peer (.clk, .rst_b, .load(peer_load), .tx_word(peer_tx), .idle_level(pol),
      .sck(sck_w), .mosi(sdo_w), .miso, .rx_word(peer_rx));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // read results are compared against the oldest note
   always @(posedge clk) begin
      cycles <= cycles + 1;
      rd_d1  <= reg_read;
      if (rd_d1) begin
         last_rdata <= reg_rdata;
         n = notes.pop_front();
         if (n.msk != 16'h0000) chk(reg_rdata & n.msk, n.exp & n.msk);
      end
      if (cycles == 60000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      notes.push_back('{e, m});
      @(posedge clk);
      reg_read <= 1'b0;
   endtask : rd
   task automatic poll(input logic [3:0] a, input int b);
      for (int i = 0; i < 3000; i++) begin
         rd(a, 16'h0000, 16'h0000);
         @(posedge clk);
         #1;
         if (last_rdata[b] === 1'b1) break;
      end
   endtask : poll
   task automatic load_peer(input logic [15:0] t);
      @(posedge clk);
      peer_tx   <= t;
      peer_load <= 1'b1;
      @(posedge clk);
      peer_load <= 1'b0;
   endtask : load_peer
   task automatic xfer(input logic [15:0] c1v, input logic [15:0] mk);
      logic [15:0] w, t, e;
      w = 16'($urandom());
      t = 16'($urandom());
      e = (mk == 16'hFFFF) ? t : {8'h00, t[15:8]};
      pol <= c1v[C1_CLOCK_POLARITY];
      wr(ADDR_CONTROL_ONE, c1v);
      wr(ADDR_STATUS_CONTROL, 16'h8000);
      repeat (4) @(posedge clk);
      chk({15'h0, sck_o}, {15'h0, c1v[C1_CLOCK_POLARITY]});
      load_peer(t);
      wr(ADDR_DATA_BUFFER, w);
      poll(ADDR_STATUS_CONTROL, STAT_RX_FULL);
      rd(ADDR_DATA_BUFFER, e, mk);
      rd(ADDR_STATUS_CONTROL, 16'h8000, 16'h80C3);
      chk(peer_rx & mk, w & mk);
      rd(ADDR_IRQ_STATUS, 16'h0003, 16'h0007);
      chk({15'h0, irq}, 16'h0001);
      wr(ADDR_IRQ_STATUS, 16'h0007);
      rd(ADDR_IRQ_STATUS, 16'h0000, 16'h0007);
      chk({15'h0, irq}, 16'h0000);
   endtask : xfer
   initial begin
      logic [15:0] t1;
      rst_b = 1'b0;
      clk_en = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      rd_d1 = 1'b0;
      pol = 1'b0;
      peer_load = 1'b0;
      ss_b = 1'b1;
      peer_tx = 16'h0000;
      bad_count = 0;
      checks = 0;
      cycles = 0;
      void'($urandom(32'h73589c08));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 8; a++) rd(4'(a), REG_RESET, 16'hFFFF);
      wr(ADDR_CONTROL_ONE, 16'hFFFF);
      rd(ADDR_CONTROL_ONE, C1_WR_MASK, 16'hFFFF);
      wr(ADDR_CONTROL_TWO, 16'hFFFE);
      rd(ADDR_CONTROL_TWO, 16'hE002, 16'hFFFF);
      wr(ADDR_CONTROL_TWO, 16'h0000);
      wr(ADDR_IRQ_MASK, 16'h0007);
      rd(ADDR_IRQ_MASK, 16'h0007, 16'hFFFF);
      xfer(16'h043D, 16'hFFFF);
      xfer(16'h007D, 16'h00FF);
      xfer(16'h073D, 16'hFFFF);
      xfer(16'h043C, 16'hFFFF);
      // overflow with the interrupt masked, then unmasked
      wr(ADDR_IRQ_MASK, 16'h0000);
      t1 = 16'($urandom());
      load_peer(t1);
      wr(ADDR_DATA_BUFFER, 16'($urandom()));
      poll(ADDR_IRQ_STATUS, IRQ_RX_FULL);
      wr(ADDR_DATA_BUFFER, 16'($urandom()));
      poll(ADDR_IRQ_STATUS, IRQ_OVERFLOW);
      chk({15'h0, irq}, 16'h0000);
      rd(ADDR_STATUS_CONTROL, 16'h8041, 16'h8041);
      wr(ADDR_IRQ_MASK, 16'h0004);
      repeat (3) @(posedge clk);
      chk({15'h0, irq}, 16'h0001);
      rd(ADDR_DATA_BUFFER, t1, 16'hFFFF);
      wr(ADDR_STATUS_CONTROL, 16'h8000);
      rd(ADDR_STATUS_CONTROL, 16'h8000, 16'h8041);
      wr(ADDR_IRQ_STATUS, 16'h0007);
      // pin release cases, judged by the checker
      wr(ADDR_CONTROL_ONE, 16'h0C3F);
      repeat (4) @(posedge clk);
      wr(ADDR_CONTROL_ONE, 16'h143F);
      repeat (4) @(posedge clk);
      wr(ADDR_CONTROL_ONE, 16'h0580);
      repeat (4) @(posedge clk);
      wr(ADDR_STATUS_CONTROL, 16'h0000);
      repeat (4) @(posedge clk);
      chk({13'h0, sck_oe, sdo_oe, ss_oe}, 16'h0000);
      tally_and_finish();
   end
endmodule : tb_top
